//--- src/hdsb_pkg.sv
// constants, state codes and carrier types of the host/dsp shared bridge
package hdsb_pkg;

  // host register file addresses
  localparam logic [7:0] RP_ADDR = 8'hFD;      // working group pointer
  localparam logic [3:0] BANK_ZERO = 4'h0;     // bank overlaid by expansion
  localparam logic [3:0] BANK_COMMON = 4'hF;   // common interface bank
  localparam logic [3:0] PORT_HI = 4'h0;       // port registers 00..03
  localparam logic [1:0] PORT_TOP = 2'h0;      // upper bits of port offsets

  // expanded file codes held in control bits 6:5
  localparam logic [1:0] FILE_A = 2'h0;
  localparam logic [1:0] FILE_B = 2'h1;
  localparam logic [1:0] FILE_C = 2'h2;
  localparam logic [1:0] FILE_D = 2'h3;

  // bank ranges of the expanded files
  localparam logic [3:0] A_DATA_LAST = 4'h9;   // data banks 1..9 of file A
  localparam logic [3:0] B_PROG_LAST = 4'hA;   // program banks 1..A of file B
  localparam logic [3:0] B_DATA_FIRST = 4'hB;  // data banks B..E of file B
  localparam logic [3:0] B_DATA_LAST = 4'hE;
  localparam logic [3:0] C_PROG_LAST = 4'hE;   // program banks 1..E of file C
  localparam logic [3:0] D_PROG_LAST = 4'h8;   // program banks 1..8 of file D

  // byte bases of program store per file
  localparam logic [8:0] PROG_BASE_B = 9'h000;
  localparam logic [8:0] PROG_BASE_C = 9'h0A0;
  localparam logic [8:0] PROG_BASE_D = 9'h180;
  // first data word seen through file B
  localparam logic [5:0] DATA_BASE_B = 6'h24;

  // common bank offsets
  localparam logic [3:0] OFS_PTR0_ALIAS = 4'h0;
  localparam logic [3:0] OFS_PTR1 = 4'h1;
  localparam logic [3:0] OFS_PTR2 = 4'h2;
  localparam logic [3:0] OFS_PTR3 = 4'h3;
  localparam logic [3:0] OFS_FLAG_HI = 4'h4;
  localparam logic [3:0] OFS_FLAG_LO = 4'h5;
  localparam logic [3:0] OFS_LAUNCH_LO = 4'h6;
  localparam logic [3:0] OFS_INJECT = 4'h7;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  localparam logic [3:0] OFS_PTR0 = 4'h9;
  localparam logic [3:0] OFS_LAUNCH_HI = 4'hA;
  localparam logic [3:0] OFS_AUTO_LO = 4'hC;
  localparam logic [3:0] OFS_AUTO_HI = 4'hD;

  // control register fields
  localparam int CTL_PAUSE = 0;
  localparam int CTL_BUSY = 1;
  localparam int CTL_CORE_RST = 2;
  localparam int CTL_AUTOSTART = 3;
  localparam int CTL_HOST_INT = 4;
  localparam int CTL_FILE_LO = 5;
  localparam logic [7:0] CTL_WMASK = 8'h7D;    // bits 7 and 1 not writable
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RD_BLOCKED = 8'h00;   // value of a blocked read

  // processor instruction classes
  localparam logic [7:0] OP_STOP = 8'h00;
  localparam logic [1:0] OP_CLASS_BRANCH = 2'h3;
  localparam logic [1:0] OP_CLASS_PTRLD = 2'h2;
  localparam logic [7:0] INJ_OPERAND = 8'h00;  // operand of injected op

  // timing
  localparam int INJ_CLOCKS = 6;
  localparam logic [2:0] INJ_LAST = 3'(INJ_CLOCKS - 1);

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    HDSB_IDLE = 5'h01,
    HDSB_RUN = 5'h02,
    HDSB_OPER = 5'h04,
    HDSB_DEAD = 5'h08,
    HDSB_INJ = 5'h10
  } hdsb_seq_t;

  // host access into the register space
  typedef struct packed {
    logic [7:0] addr;   // 8-bit register address or 4-bit short address
    logic short;        // addr[3:0] is a working register number
    logic wr;           // write strobe
    logic rd;           // read strobe
    logic [7:0] wdata;  // write data
  } hdsb_host_req_t;

  // control outputs toward the rest of the chip
  typedef struct packed {
    logic hostIntExec;  // host may run from internal memory
    logic coreReset;    // processor core reset
    logic pauseEnable;  // pause low-power mode enabled
    logic powerDown;    // processor sleeping
    logic busy;         // processor running from program store
  } hdsb_ctl_t;

  // whole module state
  typedef struct packed {
    hdsb_seq_t st;
    logic [7:0] rp;
    logic [7:0] ctrl;
    logic [3:0][7:0] ptr;
    logic [7:0] flagHi;
    logic [7:0] flagLo;
    logic [7:0] pcLo;
    logic [7:0] pcHi;
    logic [7:0] injIr;
    logic [7:0] autoLo;
    logic [7:0] autoHi;
    logic [7:0] op;
    logic [2:0] cnt;
    logic [7:0] rdata;
    logic [511:0][7:0] prog;
    logic [1:0][63:0][15:0] dram;
  } hdsb_regs_t;

endpackage

//--- src/hdsb_bridge.sv
// host/dsp shared memory bridge with launch sequencer
`timescale 1ns/1ps
`default_nettype none

module hdsb_bridge (
  input wire logic sys_clk,
  input wire logic reset,
  input wire hdsb_pkg::hdsb_host_req_t hostReq,
  input wire logic convDone,
  output logic [7:0] hostRdata,
  output logic stdAccess,
  output logic [7:0] stdAddr,
  output logic portAccessEn,
  output hdsb_pkg::hdsb_ctl_t ctl
);
  import hdsb_pkg::*;

  hdsb_regs_t s_r; // registered state
  hdsb_regs_t s_nxt; // next state

  // decode results
  logic [7:0] fullAddr; // resolved 8-bit address
  logic expSel; // an expanded bank is selected
  logic expHit; // access lands in the expanded bank
  logic [3:0] bank; // selected expanded bank
  logic [3:0] ofs; // byte offset within bank
  logic [1:0] fileSel; // selected expanded file
  logic isIface; // common interface bank
  logic isProg; // program store byte
  logic isData; // data RAM byte
  logic [8:0] progIdx; // program byte index
  logic [5:0] wordIdx; // data word index
  logic ramSel; // 1 selects the high data RAM
  logic busy; // processor runs from program store
  logic blocked; // access refused while running
  logic access; // any host strobe
  logic isPort; // port register address
  logic [8:0] pc; // current launch counter
  logic [8:0] pcInc; // launch counter plus one
  logic [7:0] fetch; // byte at the launch counter
  logic [7:0] ifaceRd; // interface register read value
  logic [7:0] memRd; // memory read value
  logic [15:0] word; // selected data word

  // processor busy when in any program store execution state
  assign busy = (s_r.st == HDSB_RUN) || (s_r.st == HDSB_OPER) ||
                (s_r.st == HDSB_DEAD);
  assign access = hostReq.wr || hostReq.rd;

  // window map as seen from the host side:
  // the pointer low nibble picks one bank of the expanded file, and that
  // bank then stands in for addresses 00..0F of the host register file.
  // the control byte bits 6:5 pick which expanded file supplies the bank.
  // bank 0 means no expansion, so the host file and its ports are reached.
  // bank F is the interface bank and looks the same from every file.
  // file A banks 1..9 carry data words 00..23, four words per bank.
  // file B banks 1..A carry program bytes 0..159 in address order.
  // file B banks B..E carry data words 24..33, four words per bank.
  // file C banks 1..E carry program bytes 160..383.
  // file D banks 1..8 carry program bytes 384..511.
  // data words 34..3F have no host window and are reached by the core only.
  // inside a data bank, offsets 0..7 go to the low ram, 8..15 to the high.
  // each word takes two offsets: even offset high byte, odd offset low.
  // banks outside these ranges decode to nothing: writes vanish and reads
  // return zero, which keeps a stray pointer from corrupting storage.
  // the pointer itself sits at FD and is never refused, so software can
  // always leave a bank, even while the processor is running.
  // address resolution and window decode
  always_comb begin
    fullAddr = hostReq.short ? {s_r.rp[7:4], hostReq.addr[3:0]}
                             : hostReq.addr;
    bank = s_r.rp[3:0];
    expSel = (bank != BANK_ZERO);
    expHit = expSel && (fullAddr[7:4] == BANK_ZERO);
    ofs = fullAddr[3:0];
    fileSel = s_r.ctrl[CTL_FILE_LO +: 2];
    isIface = expHit && (bank == BANK_COMMON);
    isProg = 1'b0;
    isData = 1'b0;
    progIdx = 9'h000;
    wordIdx = 6'h00;
    ramSel = ofs[3];
    isPort = (fullAddr[7:4] == PORT_HI) && (fullAddr[3:2] == PORT_TOP);
    if (expHit && !isIface) begin
      unique case (fileSel)
        FILE_A: begin
          // data words 00..23, four per bank
          if (bank <= A_DATA_LAST) begin
            isData = 1'b1;
            wordIdx = {2'h0, bank - 4'h1} * 6'h04 +
                      {4'h0, ofs[2:1]};
          end
        end
        FILE_B: begin
          if (bank <= B_PROG_LAST) begin
            isProg = 1'b1;
            progIdx = PROG_BASE_B + {1'b0, bank - 4'h1, ofs};
          end else if (bank <= B_DATA_LAST) begin
            isData = 1'b1;
            wordIdx = DATA_BASE_B +
                      {2'h0, bank - B_DATA_FIRST} * 6'h04 +
                      {4'h0, ofs[2:1]};
          end
        end
        FILE_C: begin
          if (bank <= C_PROG_LAST) begin
            isProg = 1'b1;
            progIdx = PROG_BASE_C + {1'b0, bank - 4'h1, ofs};
          end
        end
        FILE_D: begin
          if (bank <= D_PROG_LAST) begin
            isProg = 1'b1;
            progIdx = PROG_BASE_D + {1'b0, bank - 4'h1, ofs};
          end
        end
      endcase
    end
    // refuse memory and non-control interface access while running
    blocked = busy && (isProg || isData ||
              (isIface && (ofs != OFS_CONTROL)));
  end

  // host register file access outside the window, ports gated
  assign portAccessEn = !expSel;
  assign stdAccess = access && !expHit && (fullAddr != RP_ADDR) &&
                     !(isPort && expSel);
  assign stdAddr = fullAddr;

  // launch counter arithmetic and fetch, wrapping inside 512 bytes
  assign pc = {s_r.pcHi[0], s_r.pcLo};
  assign pcInc = pc + 9'h001;
  assign fetch = s_r.prog[pc];

  // read path notes:
  // both memories and the interface bank are muxed here every cycle, and
  // only the selected value is captured when a read strobe is taken.
  // the captured byte then stands on the output until the next read, so
  // the host may sample it at leisure one cycle or more after the strobe.
  // pointer 0 answers at two offsets so old and new software both work.
  // the busy bit is live status and is never stored in the control byte.
  // read multiplexers
  always_comb begin
    word = s_r.dram[ramSel][wordIdx];
    memRd = ofs[0] ? word[7:0] : word[15:8];
    if (isProg) begin
      memRd = s_r.prog[progIdx];
    end
    unique case (ofs)
      OFS_PTR0_ALIAS: ifaceRd = s_r.ptr[0];
      OFS_PTR1: ifaceRd = s_r.ptr[1];
      OFS_PTR2: ifaceRd = s_r.ptr[2];
      OFS_PTR3: ifaceRd = s_r.ptr[3];
      OFS_FLAG_HI: ifaceRd = s_r.flagHi;
      OFS_FLAG_LO: ifaceRd = s_r.flagLo;
      OFS_LAUNCH_LO: ifaceRd = s_r.pcLo;
      OFS_INJECT: ifaceRd = s_r.injIr;
      // busy shows in bit 1, bit 7 reads zero
      OFS_CONTROL: ifaceRd = {1'b0, s_r.ctrl[6:2], busy,
                              s_r.ctrl[CTL_PAUSE]};
      OFS_PTR0: ifaceRd = s_r.ptr[0];
      OFS_LAUNCH_HI: ifaceRd = s_r.pcHi;
      OFS_AUTO_LO: ifaceRd = s_r.autoLo;
      OFS_AUTO_HI: ifaceRd = s_r.autoHi;
      default: ifaceRd = REG_RESET; // unassigned offsets
    endcase
  end

  // sequencer timing:
  // idle is the sleeping state; powerDown follows it directly.
  // a launch write or a conversion-done start moves idle to run at once.
  // run fetches one byte per clock and executes plain ops in that clock.
  // a stop byte returns to idle on the next edge.
  // a pointer load spends one extra clock in oper to take its operand.
  // a branch spends oper on its target byte and then one dead clock while
  // the fetch restarts at the new address, three clocks in all.
  // the counter wraps at 512, so a runaway program stays in the store.
  // an injected byte uses its own path: six clocks awake, then idle,
  // without raising busy, so host access stays open while it runs.
  // a launch or injection asked for during an injection only stores the byte, and while busy it is refused;
  // the processor is never restarted underneath a running program.
  // the core reset bit overrides all of this and pins the state to idle.
  // next state: sequencer first, host access afterwards so it wins
  always_comb begin
    s_nxt = s_r;
    // processor sequencer
    unique case (s_r.st)
      HDSB_IDLE: begin
        // conversion complete launches from the shadow latch
        if (convDone && s_r.ctrl[CTL_AUTOSTART]) begin
          s_nxt.pcLo = s_r.autoLo;
          s_nxt.pcHi = s_r.autoHi;
          s_nxt.st = HDSB_RUN;
        end
      end
      HDSB_RUN: begin
        // one fetch per state time
        if (fetch == OP_STOP) begin
          s_nxt.st = HDSB_IDLE;
        end else begin
          s_nxt.pcLo = pcInc[7:0];
          s_nxt.pcHi = {7'h00, pcInc[8]};
          if (fetch[7:6] == OP_CLASS_BRANCH ||
              fetch[7:6] == OP_CLASS_PTRLD) begin
            s_nxt.op = fetch;
            s_nxt.st = HDSB_OPER;
          end
        end
      end
      HDSB_OPER: begin
        // operand byte of a two- or three-state instruction
        if (s_r.op[7:6] == OP_CLASS_BRANCH) begin
          s_nxt.pcLo = fetch;
          s_nxt.pcHi = {7'h00, s_r.op[0]};
          s_nxt.st = HDSB_DEAD;
        end else begin
          s_nxt.ptr[s_r.op[1:0]] = fetch;
          s_nxt.pcLo = pcInc[7:0];
          s_nxt.pcHi = {7'h00, pcInc[8]};
          s_nxt.st = HDSB_RUN;
        end
      end
      HDSB_DEAD: begin
        // pipeline refill after a taken branch
        s_nxt.st = HDSB_RUN;
      end
      HDSB_INJ: begin
        // injected instruction completes on its sixth clock
        if (s_r.cnt == 3'h0) begin
          if (s_r.injIr[7:6] == OP_CLASS_BRANCH) begin
            s_nxt.pcLo = INJ_OPERAND;
            s_nxt.pcHi = {7'h00, s_r.injIr[0]};
          end else if (s_r.injIr[7:6] == OP_CLASS_PTRLD) begin
            s_nxt.ptr[s_r.injIr[1:0]] = INJ_OPERAND;
          end
          s_nxt.st = HDSB_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
    endcase

    // host read, registered for the next cycle
    if (hostReq.rd) begin
      if (blocked) begin
        s_nxt.rdata = RD_BLOCKED;
      end else if (isIface) begin
        s_nxt.rdata = ifaceRd;
      end else if (isProg || isData) begin
        s_nxt.rdata = memRd;
      end else if (fullAddr == RP_ADDR) begin
        s_nxt.rdata = s_r.rp;
      end else begin
        s_nxt.rdata = REG_RESET; // held elsewhere or unmapped
      end
    end

    // host write; blocked writes leave everything unchanged
    if (hostReq.wr && !blocked) begin
      if (fullAddr == RP_ADDR) begin
        s_nxt.rp = hostReq.wdata;
      end else if (isProg) begin
        s_nxt.prog[progIdx] = hostReq.wdata;
      end else if (isData) begin
        // even byte fills bits 15:8, odd byte bits 7:0
        if (ofs[0]) begin
          s_nxt.dram[ramSel][wordIdx][7:0] = hostReq.wdata;
        end else begin
          s_nxt.dram[ramSel][wordIdx][15:8] = hostReq.wdata;
        end
      end else if (isIface) begin
        unique case (ofs)
          OFS_PTR0_ALIAS: s_nxt.ptr[0] = hostReq.wdata;
          OFS_PTR1: s_nxt.ptr[1] = hostReq.wdata;
          OFS_PTR2: s_nxt.ptr[2] = hostReq.wdata;
          OFS_PTR3: s_nxt.ptr[3] = hostReq.wdata;
          OFS_FLAG_HI: s_nxt.flagHi = hostReq.wdata;
          OFS_FLAG_LO: s_nxt.flagLo = hostReq.wdata;
          OFS_LAUNCH_LO: begin
            // low byte write launches execution from the new address
            s_nxt.pcLo = hostReq.wdata;
            if (s_r.st == HDSB_IDLE) begin
              s_nxt.st = HDSB_RUN;
            end
          end
          OFS_INJECT: begin
            // wake, run one instruction, sleep again
            s_nxt.injIr = hostReq.wdata;
            if (s_r.st == HDSB_IDLE) begin
              s_nxt.cnt = INJ_LAST;
              s_nxt.st = HDSB_INJ;
            end
          end
          OFS_CONTROL: begin
            s_nxt.ctrl = hostReq.wdata & CTL_WMASK;
          end
          OFS_PTR0: s_nxt.ptr[0] = hostReq.wdata;
          OFS_LAUNCH_HI: s_nxt.pcHi = hostReq.wdata;
          OFS_AUTO_LO: s_nxt.autoLo = hostReq.wdata;
          OFS_AUTO_HI: s_nxt.autoHi = hostReq.wdata;
          default: s_nxt.rdata = s_nxt.rdata; // unassigned offsets
        endcase
      end
    end

    // core reset holds the processor asleep
    if (s_nxt.ctrl[CTL_CORE_RST]) begin
      s_nxt.st = HDSB_IDLE;
      s_nxt.cnt = 3'h0;
    end
  end

  // refusal notes:
  // while busy, host strobes to the program store, the data rams and every
  // interface register but control are dropped without any error signal.
  // a refused write leaves storage untouched; a refused read yields zero.
  // control stays reachable so the host can always reset the core.
  // refusal is decided from the registered state, so a launch write takes
  // effect first and only the strobes after it are refused.
  // the pointer at FD and the host file outside the window are never
  // refused; they belong to the host, not to the shared storage.
  // host file accesses leave this block on stdAccess with the full address.
  // port registers are hidden while an expanded bank is selected.
  // state register; control cleared so file A is selected
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.st <= HDSB_IDLE;
      s_r.ctrl <= CTL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign hostRdata = s_r.rdata;
  assign ctl.hostIntExec = s_r.ctrl[CTL_HOST_INT];
  assign ctl.coreReset = s_r.ctrl[CTL_CORE_RST];
  assign ctl.pauseEnable = s_r.ctrl[CTL_PAUSE];
  assign ctl.powerDown = (s_r.st == HDSB_IDLE);
  assign ctl.busy = busy;

endmodule // hdsb_bridge

`default_nettype wire

//--- testbench/hdsb_bridge_sva.sv
// assertion checker for the host/dsp shared bridge ports
`timescale 1ns/1ps
`default_nettype none
module hdsb_bridge_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire hdsb_pkg::hdsb_host_req_t hostReq,
  input wire logic convDone,
  input wire logic [7:0] hostRdata,
  input wire logic stdAccess,
  input wire logic [7:0] stdAddr,
  input wire logic portAccessEn,
  input wire hdsb_pkg::hdsb_ctl_t ctl
);
  import hdsb_pkg::*;
  logic [7:0] rp_r; // pointer last written at FD
  logic [7:0] ctl_r; // control byte last written
  logic [7:0] full; // resolved strobe address
  logic strobe; // any access this cycle
  logic inF; // common bank selected
  logic launchWr; // write to launch counter low
  logic injWr; // write to injected instruction
  // resolve the address the way the host sees it
  always_comb begin
    strobe = hostReq.wr | hostReq.rd;
    full = hostReq.short ? {rp_r[7:4], hostReq.addr[3:0]} : hostReq.addr;
    inF = rp_r[3:0] == BANK_COMMON;
    launchWr = hostReq.wr & inF & (full == {4'h0, OFS_LAUNCH_LO});
    injWr = hostReq.wr & inF & (full == {4'h0, OFS_INJECT});
  end
  // shadow copies of pointer and control, never blocked
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rp_r <= 8'h00;
      ctl_r <= 8'h00;
    end else if (hostReq.wr) begin
      if (full == RP_ADDR) rp_r <= hostReq.wdata;
      if (inF && full == {4'h0, OFS_CONTROL})
        ctl_r <= hostReq.wdata & CTL_WMASK;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_short_addr: assert property (
    strobe && hostReq.short |-> stdAddr == full)
    else $error("short address resolved wrongly");
  a_host_file: assert property (
    strobe && rp_r[3:0] == BANK_ZERO && full[7:4] != 4'h0 && full < 8'hF0
    |-> stdAccess && stdAddr == full)
    else $error("host file access not passed through");
  a_port_gate: assert property (
    portAccessEn == (rp_r[3:0] == BANK_ZERO))
    else $error("port enable does not follow pointer");
  a_window_off: assert property (
    strobe && full[7:4] == BANK_ZERO && rp_r[3:0] != BANK_ZERO
    |-> !stdAccess)
    else $error("overlaid bank reached host file");
  a_ctl_bits: assert property (
    {ctl.hostIntExec, ctl.coreReset, ctl.pauseEnable}
    == {ctl_r[4], ctl_r[2], ctl_r[0]})
    else $error("control outputs differ from control byte");
  a_launch_go: assert property (
    launchWr && ctl.powerDown && !ctl.coreReset
    |=> ctl.busy && !ctl.powerDown)
    else $error("launch write did not start processor");
  a_inject_go: assert property (
    injWr && ctl.powerDown && !ctl.coreReset |=> !ctl.powerDown && !ctl.busy)
    else $error("injected instruction did not wake processor");
  a_inject_len: assert property (
    $fell(ctl.powerDown) && !ctl.busy
    |-> (!ctl.powerDown)[*6] ##1 ctl.powerDown)
    else $error("injected instruction not six clocks");
  a_auto_go: assert property (
    convDone && ctl.powerDown && !ctl.coreReset && ctl_r[CTL_AUTOSTART]
    |=> ctl.busy)
    else $error("conversion done did not autostart");
  a_auto_off: assert property (
    convDone && ctl.powerDown && !ctl_r[CTL_AUTOSTART] && !strobe
    |=> ctl.powerDown)
    else $error("autostart while disabled");
  a_core_hold: assert property (
    ctl.coreReset |=> ctl.powerDown)
    else $error("processor ran while core reset set");
  a_busy_awake: assert property (
    ctl.busy |-> !ctl.powerDown)
    else $error("busy while powered down");
  c_launch: cover property (launchWr && ctl.powerDown);
  c_inject: cover property (injWr && ctl.powerDown);
  c_auto: cover property (convDone && ctl_r[CTL_AUTOSTART]);
endmodule // hdsb_bridge_sva
`default_nettype wire

//--- testbench/hdsb_host_model.sv
// behavioural host core driving register strobes into the bridge
`timescale 1ns/1ps
`default_nettype none
module hdsb_host_model (
  input wire logic sys_clk,
  output var hdsb_pkg::hdsb_host_req_t hostReq
);
  import hdsb_pkg::*;
  // idle bus at time zero
  initial hostReq = '0;
  // one access: driven after an edge, held through the taking edge
  task automatic acc(input logic w, input logic r, input logic s,
    input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    hostReq = '{addr: a, short: s, wr: w, rd: r, wdata: d};
    @(posedge sys_clk);
    #1;
    // released strobes go low, other lines show inverted values, never stale ones
    hostReq = '{addr: ~a, short: ~s, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
endmodule // hdsb_host_model
`default_nettype wire

//--- testbench/hdsb_bridge_bench.sv
// self-checking bench of the host/dsp shared memory bridge
`timescale 1ns/1ps
`default_nettype none
module hdsb_bridge_bench;
  import hdsb_pkg::*;
  logic sys_clk = 1'b0; // 200 MHz clock
  logic reset = 1'b1; // async, active high
  logic convDone = 1'b0; // converter completion pulse
  hdsb_host_req_t hostReq; // from the host model
  logic [7:0] hostRdata, stdAddr;
  logic stdAccess, portAccessEn;
  hdsb_ctl_t ctl;
  int errors = 0, n_compared = 0, cycles = 0;
  int busyCnt = 0, busyLen = 0, awakeCnt = 0, awakeLen = 0;
  logic took = 1'b0; // a read was taken at the last edge
  logic [7:0] expQ[$]; // expected read bytes, oldest first
  logic [7:0] shadow[int]; // expected window bytes by file, bank, offset
  // nops, branch to 0A, stop, pointer 1 load of 5A, stop
  logic [7:0] prog[13] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
    8'hC0, 8'h0A, 8'h00, 8'h00, 8'h81, 8'h5A, 8'h00};
  hdsb_bridge DUT (.sys_clk(sys_clk), .reset(reset), .hostReq(hostReq),
    .convDone(convDone), .hostRdata(hostRdata), .stdAccess(stdAccess),
    .stdAddr(stdAddr), .portAccessEn(portAccessEn), .ctl(ctl));
  hdsb_host_model host (.sys_clk(sys_clk), .hostReq(hostReq));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk8(input string what, input logic [7:0] e,
    input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  // stretch lengths of busy and awake, timeout
  always @(posedge sys_clk) begin
    took <= hostReq.rd;
    cycles <= cycles + 1;
    if (ctl.busy === 1'b1) busyCnt <= busyCnt + 1;
    else if (busyCnt != 0) begin
      busyLen <= busyCnt;
      busyCnt <= 0;
    end
    if (ctl.powerDown === 1'b0) awakeCnt <= awakeCnt + 1;
    else if (awakeCnt != 0) begin
      awakeLen <= awakeCnt;
      awakeCnt <= 0;
    end
    if (cycles == 8000) begin
      errors++;
      summarize();
    end
  end
  // read data stands the cycle after the taking edge
  always @(negedge sys_clk) begin
    if (took) chk8("hostRdata", expQ.pop_front(), hostRdata);
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, 1'b0, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.acc(1'b0, 1'b1, 1'b0, a, 8'h00);
  endtask
  // reach the common bank and write control
  task automatic setCtl(input logic [7:0] c);
    wr(RP_ADDR, 8'h0F);
    wr({4'h0, OFS_CONTROL}, c);
  endtask
  // one window byte, key = file*256 + bank*16 + offset
  task automatic win(input int k, input bit r);
    setCtl(8'(k / 256 * 32));
    wr(RP_ADDR, 8'(k % 256 / 16));
    if (r) rd(8'(k % 16), shadow[k]);
    else wr(8'(k % 16), shadow[k]);
  endtask
  task automatic waitIdle();
    int i = 0;
    while (i < 60 && ctl.powerDown !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse();
    @(posedge sys_clk);
    #1 convDone = 1'b1;
    @(posedge sys_clk);
    #1 convDone = 1'b0;
  endtask
  initial begin
    void'($urandom(32'h15B32F97));
    repeat (3) @(posedge sys_clk);
    #1 reset = 1'b0;
    chk8("ctl", 8'h02, {3'h0, ctl});
    wr(RP_ADDR, 8'h0F);
    chk8("portAccessEn", 8'h00, {7'h00, portAccessEn});
    rd(8'h08, 8'h00);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h7D);
    chk8("ctl", 8'h1E, {3'h0, ctl});
    $display("control test done");
    // random bytes through mapped banks of every file
    for (int f = 0; f < 4; f++) begin
      for (int b = 1; b <= (f == 0 ? 9 : f == 3 ? 8 : 14); b++) begin
        repeat (2) shadow[f * 256 + b * 16 + int'(4'($urandom))] =
          8'($urandom);
      end
    end
    foreach (shadow[k]) win(k, 1'b0);
    foreach (shadow[k]) win(k, 1'b1);
    $display("mapping test done");
    setCtl(8'h40);
    wr(8'h0C, 8'h0A);
    wr(8'h09, 8'h3C);
    wr(8'h0B, 8'hFF);
    setCtl(8'h20);
    rd(8'h0C, 8'h0A);
    rd(8'h00, 8'h3C);
    rd(8'h0B, 8'h00);
    $display("common bank test done");
    wr(RP_ADDR, 8'h01);
    for (int i = 0; i < 13; i++) wr(8'(i), prog[i]);
    wr(RP_ADDR, 8'h0F);
    wr(8'h01, 8'h11);
    wr(8'h02, 8'h44);
    wr(8'h0A, 8'h00);
    wr(8'h06, 8'h00);
    rd(8'h08, 8'h22);
    rd(8'h01, 8'h00);
    wr(8'h02, 8'h33);
    waitIdle();
    chk8("busy length", 8'h0C, 8'(busyLen));
    rd(8'h01, 8'h5A);
    rd(8'h02, 8'h44);
    rd(8'h08, 8'h20);
    $display("launch test done");
    wr(8'h07, 8'h82);
    waitIdle();
    chk8("awake length", 8'h06, 8'(awakeLen));
    rd(8'h02, 8'h00);
    $display("inject test done");
    wr(8'h0D, 8'h00);
    wr(8'h01, 8'h00);
    pulse();
    chk8("busy", 8'h00, {7'h00, ctl.busy});
    wr(8'h08, 8'h28);
    pulse();
    waitIdle();
    chk8("busy length", 8'h03, 8'(busyLen));
    rd(8'h01, 8'h5A);
    $display("autostart test done");
    wr(8'h08, 8'h24);
    wr(8'h06, 8'h00);
    chk8("powerDown", 8'h01, {7'h00, ctl.powerDown});
    wr(8'h08, 8'h00);
    wr(RP_ADDR, 8'h30);
    chk8("portAccessEn", 8'h01, {7'h00, portAccessEn});
    host.acc(1'b1, 1'b0, 1'b1, 8'h05, 8'h99);
    wr(8'h20, 8'h55);
    $display("core reset and pointer test done");
    summarize();
  end
endmodule // hdsb_bridge_bench
bind hdsb_bridge hdsb_bridge_sva chk (.sys_clk(sys_clk), .reset(reset),
  .hostReq(hostReq), .convDone(convDone), .hostRdata(hostRdata),
  .stdAccess(stdAccess), .stdAddr(stdAddr), .portAccessEn(portAccessEn),
  .ctl(ctl));
`default_nettype wire
